// [hw/apso_defs.svh]
// Constants of the parallel sample output block
// Summary of operation
// (RL1) Start a conversion on every sample-clock rise.
// (RL2) Sample appears three sample-clock cycles after start.
// (RL3) Word and overrange change together, strobe falls.
// (RL4) Overrange high when input exceeded full scale.
// (RL5) Word bit 0 is LSB, bit 13 MSB.
// (RL6) Output word is signed two's complement.
// (RL7) Sample clock period 9.5 ns, phases 4.75 ns.
// (RL8) Receiver latches word and flag on strobe rise.
`ifndef APSO_DEFS_SVH
`define APSO_DEFS_SVH
`define APSO_WORD_W       14
`define APSO_LATENCY      3
`define APSO_FIFO_DEPTH   32
`define APSO_CLK_NS       5
`define APSO_MIN_PER_PS   9500
`define APSO_MIN_PHASE_PS 4750
`define APSO_MIN_PER_CYC  ((`APSO_MIN_PER_PS + `APSO_CLK_NS*1000 - 1) / (`APSO_CLK_NS*1000))
`define APSO_MIN_PH_CYC   ((`APSO_MIN_PHASE_PS + `APSO_CLK_NS*1000 - 1) / (`APSO_CLK_NS*1000))
`endif

// [hw/apso_pkg.sv]
// Types of the parallel sample output block
package apso_pkg;
   // One converted sample with its overrange flag
   typedef struct packed
   {
      logic               overrange_flag;
      logic signed [13:0] word;
   } apso_sample_type;
endpackage

// [hw/apso_fifo.sv]
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module apso_fifo #(
   parameter int WIDTH = 15,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic             i_sys_clk,
   input  wire logic             i_nrst,
   // Fill side
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   // Drain side
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];       // Storage
   logic [AW-1:0]    wr_q;                // Write index
   logic [AW-1:0]    rd_q;                // Read index
   logic [AW:0]      cnt_q;               // Fill level
   logic             push;
   logic             pop;

   assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_q != '0);
   assign o_out_data  = mem_q[rd_q];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   // Storage write, no reset needed on data
   always_ff @(posedge i_sys_clk)
   begin
      if (push)
      begin
         mem_q[wr_q] <= i_in_data;
      end
   end

   // Indices and level
   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + AW'(1);
         end
         if (pop)
         begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + AW'(1);
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// [hw/apso_pipe.sv]
// Conversion latency pipeline advanced on sample-clock rises
`timescale 1ns/1ps
module apso_pipe #(
   parameter int WIDTH   = 15,
   parameter int LATENCY = 3
) (
   // Clock and reset
   input  wire logic             i_sys_clk,
   input  wire logic             i_nrst,
   // Advance strobe and data
   input  wire logic             i_adv,
   input  wire logic [WIDTH-1:0] i_data,
   output logic      [WIDTH-1:0] o_data
);
   logic [WIDTH-1:0] stage_q [LATENCY];   // Pipeline stages

   // One stage per sample-clock cycle of latency
   generate
      for (genvar g = 0; g < LATENCY; g++)
      begin : g_stage
         always_ff @(posedge i_sys_clk or negedge i_nrst)
         begin
            if (!i_nrst)
            begin
               stage_q[g] <= '0;
            end
            else if (i_adv)
            begin
               stage_q[g] <= (g == 0) ? i_data : stage_q[(g == 0) ? 0 : g-1]; // RL2
            end
         end
      end
   endgenerate

   assign o_data = stage_q[LATENCY-1];
endmodule

// [hw/apso_top.sv]
// Parallel sample output side of a pipelined sampling converter
`timescale 1ns/1ps
`include "apso_defs.svh"
module apso_top #(
   parameter int WIDTH      = `APSO_WORD_W,
   parameter int LATENCY    = `APSO_LATENCY,
   parameter int FIFO_DEPTH = `APSO_FIFO_DEPTH
) (
   // System clock and reset
   input  wire logic              i_sys_clk,
   input  wire logic              i_nrst,
   // Sample clock from the receiver (asynchronous)
   input  wire logic              i_sample_clk,
   // Quantised analog value and overrange indication
   input  wire logic [WIDTH-1:0]  i_analog_code,
   input  wire logic              i_analog_over,
   // Parallel sample output
   output logic      [WIDTH-1:0]  o_sample_word,
   output logic                   o_overrange_flag,
   output logic                   o_sample_valid_strobe,
   // Status
   output logic                   o_fifo_full,
   output logic                   o_clk_too_fast
);
   localparam int SW = WIDTH + 1;
   localparam int CW = 8;

   logic [2:0]    clk_sync_q;             // Three-stage sampler
   logic          clk_lvl_q;              // Agreed level
   logic          rise;                   // Sample-clock rise
   logic          fall;                   // Sample-clock fall
   logic [CW-1:0] per_cnt_q;              // Cycles since last rise
   logic [CW-1:0] ph_cnt_q;               // Cycles since last edge
   logic [SW-1:0] cap_q;                  // Captured sample
   logic          cap_vld_q;              // Capture pending for FIFO
   logic          in_ready;
   logic          out_valid;
   logic [SW-1:0] out_data;
   logic [SW-1:0] pipe_out;
   logic          pop;

   // Synchronise sample clock; middle and last stages must agree
   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         clk_sync_q <= 3'h0;
         clk_lvl_q  <= 1'b0;
      end
      else
      begin
         clk_sync_q <= {clk_sync_q[1:0], i_sample_clk};
         if (clk_sync_q[1] == clk_sync_q[2])
         begin
            clk_lvl_q <= clk_sync_q[2];
         end
      end
   end

   assign rise = (clk_sync_q[1] == clk_sync_q[2]) & clk_sync_q[2] & ~clk_lvl_q;
   assign fall = (clk_sync_q[1] == clk_sync_q[2]) & ~clk_sync_q[2] & clk_lvl_q;

   // Capture a new sample on each rise; this is the start of conversion
   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         cap_q     <= '0;
         cap_vld_q <= 1'b0;
      end
      else
      begin
         if (rise)
         begin
            // Word keeps bit 0 as LSB; input already two's complement
            cap_q     <= {i_analog_over, i_analog_code}; // RL1 RL4 RL5 RL6
            cap_vld_q <= 1'b1;                           // RL1
         end
         else if (in_ready)
         begin
            cap_vld_q <= 1'b0;
         end
      end
   end

   // Elastic store between capture and the latency pipe
   apso_fifo #(
      .WIDTH (SW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_sys_clk   (i_sys_clk),
      .i_nrst      (i_nrst),
      .i_in_valid  (cap_vld_q),
      .o_in_ready  (in_ready),
      .i_in_data   (cap_q),
      .o_out_valid (out_valid),
      .i_out_ready (rise),
      .o_out_data  (out_data)
   );

   // Drain only on a rise; an empty store feeds zero
   assign pop = rise & out_valid;

   // Latency pipe advanced once per sample-clock rise
   apso_pipe #(
      .WIDTH   (SW),
      .LATENCY (LATENCY - 1)
   ) u_pipe (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (i_nrst),
      .i_adv     (rise),
      .i_data    (pop ? out_data : '0),
      .o_data    (pipe_out)
   );

   // Word and flag change together at the rise, strobe falls there
   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_sample_word         <= '0;
         o_overrange_flag      <= 1'b0;
         o_sample_valid_strobe <= 1'b0;
      end
      else
      begin
         if (rise)
         begin
            o_sample_word         <= pipe_out[WIDTH-1:0]; // RL2 RL3
            o_overrange_flag      <= pipe_out[WIDTH];     // RL3 RL4
            o_sample_valid_strobe <= 1'b0;                // RL3
         end
         else if (fall)
         begin
            // Strobe rises mid-cycle so data is stable at its edge
            o_sample_valid_strobe <= 1'b1;
         end
      end
   end

   // Watch the supplied clock against its minimum period and phase
   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         per_cnt_q      <= '1;
         ph_cnt_q       <= '1;
         o_clk_too_fast <= 1'b0;
         o_fifo_full    <= 1'b0;
      end
      else
      begin
         o_fifo_full <= ~in_ready;
         if (rise | fall)
         begin
            ph_cnt_q <= '0;
         end
         else if (ph_cnt_q != '1)
         begin
            ph_cnt_q <= ph_cnt_q + CW'(1);
         end
         if (rise)
         begin
            per_cnt_q <= '0;
         end
         else if (per_cnt_q != '1)
         begin
            per_cnt_q <= per_cnt_q + CW'(1);
         end
         // Sticky flag; resolution is one system clock
         // A saturated count means no recent edge; without the guard it wraps to zero
         if ((rise | fall) && (ph_cnt_q != '1) && (ph_cnt_q + CW'(1) < CW'(`APSO_MIN_PH_CYC)))
         begin
            o_clk_too_fast <= 1'b1; // RL7
         end
         if (rise && (per_cnt_q != '1) && (per_cnt_q + CW'(1) < CW'(`APSO_MIN_PER_CYC)))
         begin
            o_clk_too_fast <= 1'b1; // RL7
         end
      end
   end
endmodule

// [bench/apso_checker.sv]
// Timing checker of the parallel sample output block
`timescale 1ns/1ps
module apso_checker #(
   parameter int WIDTH   = 14,
   parameter int LATENCY = 3
) (
   // Watched ports
   input wire logic             i_sys_clk,
   input wire logic             i_nrst,
   input wire logic             i_sample_clk,
   input wire logic [WIDTH-1:0] i_analog_code,
   input wire logic             i_analog_over,
   input wire logic [WIDTH-1:0] o_sample_word,
   input wire logic             o_overrange_flag,
   input wire logic             o_sample_valid_strobe,
   input wire logic             o_fifo_full,
   input wire logic             o_clk_too_fast
);
   default clocking dc @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_nrst);
   logic           strb_q;           // Strobe one cycle ago
   logic [WIDTH:0] hist_q [LATENCY]; // Inputs per sample, newest first
   logic [7:0]     fill_q;           // Samples seen, saturating
   wire            rise_w = o_sample_valid_strobe & ~strb_q;
   // History keyed on strobe rises, since the first rise after reset shows no fall
   always_ff @(posedge i_sys_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         strb_q <= 1'b0;
         fill_q <= 8'h00;
         for (int k = 0; k < LATENCY; k++)
            hist_q[k] <= '0;
      end
      else
      begin
         strb_q <= o_sample_valid_strobe;
         if (rise_w)
         begin
            hist_q[0] <= {i_analog_over, i_analog_code};
            for (int k = 1; k < LATENCY; k++)
               hist_q[k] <= hist_q[k-1];
            if (fill_q < LATENCY)
               fill_q <= fill_q + 8'h01;
         end
      end
   end
   a_word_on_fall: assert property ($changed(o_sample_word) |-> $fell(o_sample_valid_strobe))
      else $error("word moved off a strobe fall");
   a_flag_on_fall: assert property ($changed(o_overrange_flag) |-> $fell(o_sample_valid_strobe))
      else $error("flag moved off a strobe fall");
   a_rise_starts: assert property ($rose(i_sample_clk) |-> ##[2:6] !o_sample_valid_strobe)
      else $error("sample clock rise not taken");
   a_fall_valid: assert property ($fell(i_sample_clk) |-> ##[2:6] o_sample_valid_strobe)
      else $error("strobe did not rise after clock fall");
   a_word_latency: assert property (rise_w && fill_q == LATENCY |->
      o_sample_word == hist_q[LATENCY-1][WIDTH-1:0]) else $error("word latency wrong");
   a_flag_latency: assert property (rise_w && fill_q == LATENCY |->
      o_overrange_flag == hist_q[LATENCY-1][WIDTH]) else $error("overrange flag wrong");
   a_early_zero: assert property (rise_w && fill_q < LATENCY |->
      o_sample_word == '0 && !o_overrange_flag) else $error("output before pipeline filled");
   a_still_on_rise: assert property ($rose(o_sample_valid_strobe) |->
      $stable(o_sample_word) && $stable(o_overrange_flag)) else $error("word moved on strobe rise");
   // Main scenarios
   c_full_over: cover property (rise_w && fill_q == LATENCY && o_overrange_flag);
   c_negative: cover property (rise_w && o_sample_word[WIDTH-1]);
   c_strobe_fall: cover property ($fell(o_sample_valid_strobe));
endmodule
bind apso_top apso_checker #(.WIDTH(WIDTH), .LATENCY(LATENCY)) chk_u (
   .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_sample_clk(i_sample_clk),
   .i_analog_code(i_analog_code), .i_analog_over(i_analog_over),
   .o_sample_word(o_sample_word), .o_overrange_flag(o_overrange_flag),
   .o_sample_valid_strobe(o_sample_valid_strobe), .o_fifo_full(o_fifo_full),
   .o_clk_too_fast(o_clk_too_fast));

// [bench/apso_rx_model.sv]
// Receiver model: sample clock source and sample capture
`timescale 1ns/1ps
module apso_rx_model #(
   parameter realtime HALF_NS = 80.0
) (
   // Control and capture
   input  wire logic                 i_run,
   input  wire logic [13:0]          i_sample_word,
   input  wire logic                 i_overrange_flag,
   input  wire logic                 i_sample_valid_strobe,
   output logic                      o_sample_clk,
   output apso_pkg::apso_sample_type o_latched
);
   // Clock stands low unless enabled; a period always completes whole
   initial o_sample_clk = 1'b0;
   always
   begin
      wait (i_run);
      #(HALF_NS) o_sample_clk = 1'b1;
      #(HALF_NS) o_sample_clk = 1'b0;
   end
   // Word and flag taken as one sample
   always @(posedge i_sample_valid_strobe)
      o_latched <= {i_overrange_flag, i_sample_word};
endmodule

// [bench/test_apso_top.sv]
// Self-checking bench of the parallel sample output block
`timescale 1ns/1ps
module test_apso_top;
   logic                      i_sys_clk = 1'b0;      // System clock
   logic                      i_nrst = 1'b0;         // Reset, active low
   logic [13:0]               i_analog_code = 14'h0000;
   logic                      i_analog_over = 1'b0;
   logic                      run = 1'b0;            // Sample clock enable
   logic                      sample_clk;            // From receiver model
   logic [13:0]               o_sample_word;
   logic                      o_overrange_flag;
   logic                      o_sample_valid_strobe;
   logic                      o_fifo_full;
   logic                      o_clk_too_fast;
   apso_pkg::apso_sample_type latched;               // Receiver capture
   apso_pkg::apso_sample_type exp_s;                 // Expected capture
   int                        errors = 0;
   int                        compares = 0;
   // Extremes, sign and overrange; trailing zeros flush the pipeline
   apso_pkg::apso_sample_type rows [11] = '{'{1'b1,14'h1FFF}, '{1'b1,14'h2000},
      '{1'b0,14'h3FFF}, '{1'b0,14'h0001}, '{1'b0,14'h2AAA}, '{1'b1,14'h1555},
      '{1'b0,14'h0100}, '{1'b1,14'h0000}, '{1'b0,14'h0000}, '{1'b0,14'h0000}, '{1'b0,14'h0000}};
   always #2.5 i_sys_clk = ~i_sys_clk;
   apso_top dut_u (
      .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_sample_clk(sample_clk),
      .i_analog_code(i_analog_code), .i_analog_over(i_analog_over),
      .o_sample_word(o_sample_word), .o_overrange_flag(o_overrange_flag),
      .o_sample_valid_strobe(o_sample_valid_strobe), .o_fifo_full(o_fifo_full),
      .o_clk_too_fast(o_clk_too_fast));
   apso_rx_model rx_u (
      .i_run(run), .i_sample_word(o_sample_word), .i_overrange_flag(o_overrange_flag),
      .i_sample_valid_strobe(o_sample_valid_strobe), .o_sample_clk(sample_clk),
      .o_latched(latched));
   // Report the counts and the verdict, then stop
   task automatic finish_test();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Feed n rows back to back; each capture shows the row three samples older
   task automatic play(input int n);
      for (int i = 0; i < n; i++)
      begin
         i_analog_over <= rows[i].overrange_flag;
         i_analog_code <= rows[i].word;
         @(posedge o_sample_valid_strobe);
         @(posedge i_sys_clk);
         exp_s = '0;
         if (i >= 3)
            exp_s = rows[i-3];
         compares++;
         if (latched !== exp_s)
         begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, latched, exp_s);
         end
      end
   endtask
   // Start the sample clock off the system clock's phase
   task automatic start_run();
      @(posedge i_sys_clk);
      #1.3 run = 1'b1;
      @(posedge i_sys_clk);
   endtask
   initial
   begin
      repeat (3) @(posedge i_sys_clk);
      i_nrst <= 1'b1;
      start_run();
      play(11);
      $display("test table done");
      // Reset with the sample clock stopped must empty the pipeline; the final period leaves an overrange 1FFF sample inside
      i_analog_over <= 1'b1;
      i_analog_code <= 14'h1FFF;
      run = 1'b0;
      repeat (40) @(posedge i_sys_clk);
      i_nrst <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
      compares++;
      if ({o_sample_word, o_overrange_flag, o_sample_valid_strobe, o_fifo_full,
           o_clk_too_fast} !== 18'h00000)
      begin
         errors++;
         $display("BAD %0t outputs not cleared by reset", $time);
      end
      i_nrst <= 1'b1;
      start_run();
      play(4);
      compares++;
      if (o_fifo_full !== 1'b0 || o_clk_too_fast !== 1'b0)
      begin
         errors++;
         $display("BAD %0t status raised in normal use", $time);
      end
      $display("test reset done");
      finish_test();
   end
   // Watchdog well beyond the expected few microseconds
   initial
   begin
      #20000;
      errors++;
      finish_test();
   end
endmodule
